// ==== hw/ssf_port.sv ====
// spi secondary frame port: serial link on sclk, frame checking and register strobes on clk
`timescale 1ns/1ps
`default_nettype none
`include "ssf_consts.svh"
module ssf_port #(
    parameter int ADDR_W = 7,
    parameter int DATA_W = 16
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic SDI,
    output logic SDO,
    output logic SDO_OE,
    input wire logic CRC_EN,
    input wire ssf_pkg::ssf_flags_t FAULT_SUMMARY,
    output logic [ADDR_W-1:0] RD_ADDR,
    input wire logic [DATA_W-1:0] RD_DATA,
    output logic WR_STB,
    output logic [ADDR_W-1:0] WR_ADDR,
    output logic [DATA_W-1:0] WR_DATA,
    output logic RC_STB,
    output logic SPI_ERR,
    input wire logic SPI_ERR_CLR
);
    import ssf_pkg::*;

    if (ADDR_W + DATA_W + 1 != 24) begin : g_chk
        $error("ssf_port: address, data and rw bit must fill a 24-bit frame");
    end

    // clk domain state
    logic cs_meta_r;
    logic cs_sync_r;
    ssf_state_e state_r;
    logic link_clr_r;
    logic [31:0] tx_word_r;
    logic crc_en_frame_r;
    ssf_cnt_t cnt_cap_r;
    logic [31:0] word_cap_r;
    logic [DATA_W-1:0] resp_data_r;
    logic spi_err_r;
    logic sdo_oe_r;
    logic wr_stb_r;
    logic rc_stb_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic rw_r;
    logic ok_r;
    // sclk domain state
    ssf_cnt_t rx_cnt_r;
    logic [31:0] rx_shift_r;
    ssf_cnt_t tx_cnt_r;
    logic sdo_r;

    logic [23:0] rx_frame;
    ssf_crc_t rx_crc;
    ssf_crc_t tx_crc;
    ssf_crc_t crc_ok_crc;
    ssf_cnt_t exp_len;
    ssf_flags_t flags_nxt;
    logic len_ok;
    logic crc_ok;

    // ---------------- chip select crossing ----------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cs_meta_r <= 1'b1;
            cs_sync_r <= 1'b1;
        end else begin
            cs_meta_r <= CS_N;
            cs_sync_r <= cs_meta_r;
        end
    end

    // ---------------- frame sequencing ----------------
    // idle and frame states follow the synced level, so a short high gap is not missed
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_r <= SSF_IDLE;
        end else begin
            unique case (state_r)
                SSF_IDLE: begin
                    if (!cs_sync_r) begin
                        state_r <= SSF_FRAME;
                    end
                end
                SSF_FRAME: begin
                    if (cs_sync_r) begin
                        state_r <= SSF_EVAL;
                    end
                end
                SSF_EVAL: begin
                    state_r <= SSF_APPLY;
                end
                SSF_APPLY: begin
                    state_r <= SSF_IDLE;
                end
            endcase
        end
    end

    // link logic is held cleared between frames; sclk edges then change nothing
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            link_clr_r <= 1'b1;
        end else if (state_r == SSF_IDLE && !cs_sync_r) begin
            link_clr_r <= 1'b0;
        end else if (state_r == SSF_APPLY) begin
            link_clr_r <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sdo_oe_r <= 1'b0;
        end else begin
            sdo_oe_r <= !cs_sync_r;
        end
    end

    // ---------------- response snapshot ----------------
    always_comb begin
        flags_nxt = FAULT_SUMMARY;
        flags_nxt[`SSF_ERR_BIT] = FAULT_SUMMARY[`SSF_ERR_BIT] | spi_err_r;
    end

    ssf_crc4 #(
        .W(24)
    ) u_tx_crc (
        .data({flags_nxt, resp_data_r}),
        .crc(tx_crc)
    );

    // the word is loaded on the same clk edge that link_clr drops and stays put for the whole frame
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            tx_word_r <= 32'h0000_0000;
            crc_en_frame_r <= 1'b0;
        end else if (state_r == SSF_IDLE && !cs_sync_r) begin
            tx_word_r <= {flags_nxt, resp_data_r, 4'h0, tx_crc};
            crc_en_frame_r <= CRC_EN;
        end
    end

    // ---------------- serial side ----------------
    always_ff @(negedge SCLK or posedge link_clr_r) begin
        if (link_clr_r) begin
            rx_cnt_r <= 6'h00;
            rx_shift_r <= 32'h0000_0000;
        end else begin
            rx_shift_r <= {rx_shift_r[30:0], SDI};
            rx_cnt_r <= (rx_cnt_r == `SSF_CNT_MAX) ? rx_cnt_r : rx_cnt_r + 6'h01;
        end
    end

    // first rising edge of a frame puts bit 31 of the word, the flags msb, out
    always_ff @(posedge SCLK or posedge link_clr_r) begin
        if (link_clr_r) begin
            tx_cnt_r <= 6'h00;
            sdo_r <= `SSF_SDO_IDLE;
        end else begin
            sdo_r <= tx_cnt_r[5] ? 1'b0 : tx_word_r[5'd31 - tx_cnt_r[4:0]];
            tx_cnt_r <= (tx_cnt_r == `SSF_CNT_MAX) ? tx_cnt_r : tx_cnt_r + 6'h01;
        end
    end

    // ---------------- frame checking ----------------
    // rx registers are quiet once chip select has risen, two sync stages ago
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cnt_cap_r <= 6'h00;
            word_cap_r <= 32'h0000_0000;
        end else if (state_r == SSF_FRAME && cs_sync_r) begin
            cnt_cap_r <= rx_cnt_r;
            word_cap_r <= rx_shift_r;
        end
    end

    assign exp_len = crc_en_frame_r ? `SSF_CRC_FRAME_BITS : `SSF_FRAME_BITS;
    assign rx_frame = crc_en_frame_r ? word_cap_r[31:8] : word_cap_r[23:0];
    assign rx_crc = word_cap_r[`SSF_CRC_FIELD_MSB:0];

    ssf_crc4 #(
        .W(24)
    ) u_rx_crc (
        .data(rx_frame),
        .crc(crc_ok_crc)
    );

    assign len_ok = (cnt_cap_r == exp_len);
    assign crc_ok = !crc_en_frame_r || (crc_ok_crc == rx_crc);

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ok_r <= 1'b0;
            rw_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= '0;
        end else if (state_r == SSF_EVAL) begin
            ok_r <= len_ok && crc_ok;
            rw_r <= rx_frame[`SSF_RW_BIT];
            addr_r <= rx_frame[`SSF_ADDR_MSB:`SSF_ADDR_LSB];
            wdata_r <= rx_frame[`SSF_DATA_MSB:0];
        end
    end

    // ---------------- register side effects ----------------
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            wr_stb_r <= 1'b0;
            rc_stb_r <= 1'b0;
        end else begin
            wr_stb_r <= (state_r == SSF_APPLY) && ok_r && rw_r;
            rc_stb_r <= (state_r == SSF_APPLY) && ok_r && !rw_r;
        end
    end

    // read data is taken before the clear strobe reaches the register
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            resp_data_r <= `SSF_RESP_RESET;
        end else if (state_r == SSF_APPLY && ok_r) begin
            resp_data_r <= rw_r ? wdata_r : RD_DATA;
        end
    end

    // a bad frame keeps the old response; set wins over a clear in the same cycle
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            spi_err_r <= 1'b0;
        end else if (state_r == SSF_APPLY && !ok_r && cnt_cap_r != 6'h00) begin
            spi_err_r <= 1'b1;
        end else if (SPI_ERR_CLR) begin
            spi_err_r <= 1'b0;
        end
    end

    assign SDO = sdo_r;
    assign SDO_OE = sdo_oe_r;
    assign RD_ADDR = addr_r;
    assign WR_STB = wr_stb_r;
    assign WR_ADDR = addr_r;
    assign WR_DATA = wdata_r;
    assign RC_STB = rc_stb_r;
    assign SPI_ERR = spi_err_r;

    // ---------------- checks ----------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    wr_needs_ok_a: assert property (wr_stb_r |-> len_ok && crc_ok && rw_r)
        else $error("write strobe without a clean write frame");
    wr_single_a: assert property (wr_stb_r |=> !wr_stb_r)
        else $error("write strobe longer than one cycle");
    rc_needs_ok_a: assert property (rc_stb_r |-> len_ok && crc_ok && !rw_r)
        else $error("read clear strobe without a clean read frame");
    len_error_a: assert property ((state_r == SSF_APPLY && !len_ok && cnt_cap_r != 6'h00) |=> spi_err_r)
        else $error("length error not flagged");
    bad_no_wr_a: assert property ((state_r == SSF_APPLY && !ok_r) |=> !wr_stb_r && !rc_stb_r)
        else $error("bad frame produced a strobe");
    empty_no_err_a: assert property ((state_r == SSF_APPLY && cnt_cap_r == 6'h00 && !spi_err_r
        && !SPI_ERR_CLR) |=> !spi_err_r)
        else $error("empty chip select pulse flagged an error");
    snap_flags_a: assert property ((state_r == SSF_IDLE && !cs_sync_r)
        |=> tx_word_r[`SSF_FLAGS_MSB:`SSF_FLAGS_LSB] == $past(flags_nxt))
        else $error("fault snapshot not taken at frame start");
    err_report_a: assert property ((state_r == SSF_IDLE && !cs_sync_r && spi_err_r)
        |=> tx_word_r[`SSF_FLAGS_LSB + `SSF_ERR_BIT])
        else $error("pending error not placed in the response flags");
    resp_prev_a: assert property ((state_r == SSF_APPLY && ok_r && rw_r)
        |=> resp_data_r == $past(wdata_r) ##1 state_r == SSF_IDLE)
        else $error("response data does not follow the previous command");
    resp_layout_a: assert property ((state_r == SSF_IDLE && !cs_sync_r)
        |=> tx_word_r[`SSF_RESP_MSB:`SSF_RESP_LSB] == $past(resp_data_r))
        else $error("response data misplaced in the output word");
    oe_off_a: assert property (cs_sync_r [*2] |-> !sdo_oe_r)
        else $error("sdo driven while chip select is high");
    link_hold_a: assert property ((state_r == SSF_IDLE && cs_sync_r) |-> link_clr_r)
        else $error("link logic live outside a frame");

    ok_write_c: cover property (wr_stb_r);
    ok_read_c: cover property (rc_stb_r);
    crc_err_c: cover property (state_r == SSF_APPLY && crc_en_frame_r && len_ok && !crc_ok);
    empty_pulse_c: cover property (state_r == SSF_APPLY && cnt_cap_r == 6'h00);
endmodule
`default_nettype wire

// ==== hw/ssf_consts.svh ====
// constants of the spi secondary frame port: frame layout, crc and reset values
`ifndef SSF_CONSTS_SVH
`define SSF_CONSTS_SVH

`define SSF_FRAME_BITS 6'd24
`define SSF_CRC_FRAME_BITS 6'd32
`define SSF_CNT_MAX 6'd63
`define SSF_RW_BIT 23
`define SSF_ADDR_MSB 22
`define SSF_ADDR_LSB 16
`define SSF_DATA_MSB 15
`define SSF_CRC_FIELD_MSB 3
`define SSF_FLAGS_MSB 31
`define SSF_FLAGS_LSB 24
`define SSF_RESP_MSB 23
`define SSF_RESP_LSB 8
`define SSF_ERR_BIT 0
`define SSF_CRC_SEED 4'hf
`define SSF_CRC_POLY 4'h3
`define SSF_SDO_IDLE 1'b1
`define SSF_RESP_RESET 16'h0000

`endif

// ==== hw/ssf_pkg.sv ====
// types shared by the spi secondary frame port
package ssf_pkg;
    typedef enum logic [1:0] {
        SSF_IDLE,
        SSF_FRAME,
        SSF_EVAL,
        SSF_APPLY
    } ssf_state_e;
    typedef logic [5:0] ssf_cnt_t;
    typedef logic [7:0] ssf_flags_t;
    typedef logic [3:0] ssf_crc_t;
endpackage

// ==== hw/ssf_crc4.sv ====
// combinational crc-4 over a word, msb first
`timescale 1ns/1ps
`default_nettype none
`include "ssf_consts.svh"
module ssf_crc4 #(
    parameter int W = 24
) (
    input wire logic [W-1:0] data,
    output var ssf_pkg::ssf_crc_t crc
);
    import ssf_pkg::*;

    if (W < 1) begin : g_chk
        $error("ssf_crc4: width must be at least one");
    end

    always_comb begin
        ssf_crc_t c;
        logic fb;
        c = `SSF_CRC_SEED;
        fb = 1'b0;
        for (int i = W - 1; i >= 0; i--) begin
            fb = c[3] ^ data[i];
            c = {c[2:0], 1'b0} ^ (fb ? `SSF_CRC_POLY : 4'h0);
        end
        crc = c;
    end
endmodule
`default_nettype wire

// ==== sim/ssf_host_model.sv ====
// host spi primary model: frames on a 30 ns serial clock that stands still between frames except in stray_clocks
`timescale 1ns/1ps
`default_nettype none
module ssf_host_model (
    output logic SCLK,
    output logic CS_N,
    output logic SDI,
    input wire logic SDO_W
);
    initial begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        SDI = 1'b0;
    end
    // nbits of word, msb first; rx gathers sdo as sampled on each falling edge
    task automatic xfer(input logic [31:0] word, input int nbits, output logic [31:0] rx);
        rx = '0;
        #7 CS_N = 1'b0;
        #60;
        for (int i = nbits - 1; i >= 0; i--) begin
            #5 SDI = word[i];
            #10 SCLK = 1'b1;
            #15 SCLK = 1'b0;
            rx = {rx[30:0], SDO_W};
        end
        #30 CS_N = 1'b1;
        SDI = ~SDI; // released line must not keep its last value
        #150;
    endtask
    // stray clocks with chip select high, on purpose
    task automatic stray_clocks();
        repeat (3) begin
            #15 SCLK = 1'b1;
            #15 SCLK = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ==== sim/test_ssf_port.sv ====
// self-checking bench of the spi secondary frame port against a host model
`timescale 1ns/1ps
`default_nettype none
module test_ssf_port;
    import ssf_pkg::*;
    logic CLK, SYS_RST, CRC_EN, SPI_ERR_CLR, SCLK, CS_N, SDI, SDO, SDO_OE, sdo_w, WR_STB, RC_STB, SPI_ERR;
    ssf_flags_t FAULT_SUMMARY;
    logic [6:0] RD_ADDR, WR_ADDR, last_wa;
    logic [15:0] RD_DATA, WR_DATA, last_wd, exp_resp;
    logic [31:0] rx;
    logic [23:0] w;
    int err_count, num_checks, wr_cnt, rc_cnt, w0, r0;
    assign sdo_w = SDO_OE ? SDO : 1'b1; // pull-up while released
    assign RD_DATA = {RD_ADDR, 9'h0a5};
    ssf_port DUT (.CLK(CLK), .SYS_RST(SYS_RST), .SCLK(SCLK), .CS_N(CS_N), .SDI(SDI), .SDO(SDO),
        .SDO_OE(SDO_OE), .CRC_EN(CRC_EN), .FAULT_SUMMARY(FAULT_SUMMARY), .RD_ADDR(RD_ADDR),
        .RD_DATA(RD_DATA), .WR_STB(WR_STB), .WR_ADDR(WR_ADDR), .WR_DATA(WR_DATA), .RC_STB(RC_STB),
        .SPI_ERR(SPI_ERR), .SPI_ERR_CLR(SPI_ERR_CLR));
    ssf_host_model HOST (.SCLK(SCLK), .CS_N(CS_N), .SDI(SDI), .SDO_W(sdo_w));
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        if (WR_STB === 1'b1) begin
            wr_cnt++;
            last_wa = WR_ADDR;
            last_wd = WR_DATA;
        end
        if (RC_STB === 1'b1) begin
            rc_cnt++;
            last_wa = RD_ADDR;
        end
    end
    task automatic close_out();
        if (err_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string msg);
        chk_val({31'h0, got}, {31'h0, exp}, msg);
    endtask
    function automatic logic [3:0] crc4(input logic [23:0] d);
        logic [3:0] c;
        logic fb;
        c = 4'hf;
        for (int i = 23; i >= 0; i--) begin
            fb = c[3] ^ d[i];
            c = {c[2:0], 1'b0} ^ {2'b00, fb, fb};
        end
        return c;
    endfunction
    task automatic clear_err();
        @(negedge CLK) SPI_ERR_CLR = 1'b1;
        @(negedge CLK) SPI_ERR_CLR = 1'b0;
        @(negedge CLK) chk_bit(SPI_ERR, 1'b0, "error clear");
    endtask
    task automatic t_write();
        w0 = wr_cnt;
        // faults change after the first flag bit is out: the frame must still carry the snapshot
        fork
            HOST.xfer({8'h00, 1'b1, 7'h15, 16'hbeef}, 24, rx);
            begin
                #90;
                @(negedge CLK) FAULT_SUMMARY = 8'h3c;
            end
        join
        chk_val(wr_cnt, w0 + 1, "write strobe");
        chk_val(last_wa, 7'h15, "write address");
        chk_val(last_wd, 16'hbeef, "write data");
        chk_val(rx[23:16], 8'h5a, "flags");
        chk_val(rx[15:0], 16'h0000, "reset response");
        chk_bit(SDO_OE, 1'b0, "sdo released");
    endtask
    task automatic t_read();
        w0 = wr_cnt;
        r0 = rc_cnt;
        HOST.xfer({8'h00, 1'b0, 7'h2c, 16'h1234}, 24, rx);
        chk_val(rx[15:0], 16'hbeef, "response after write");
        chk_val(rx[23:16], 8'h3c, "new fault snapshot");
        chk_val(rc_cnt, r0 + 1, "read clear strobe");
        chk_val(wr_cnt, w0, "no write on read");
        chk_val(last_wa, 7'h2c, "read address");
        exp_resp = {7'h2c, 9'h0a5};
    endtask
    task automatic t_bad_len();
        w = 24'haaaaaa;
        for (int n = 23; n <= 25; n += 2) begin
            clear_err();
            w0 = wr_cnt;
            r0 = rc_cnt;
            HOST.xfer({8'h00, w}, n, rx);
            chk_bit(SPI_ERR, 1'b1, "length error");
            chk_val(wr_cnt + rc_cnt, w0 + r0, "no strobe on bad frame");
        end
        HOST.xfer({8'h00, 1'b0, 7'h33, 16'h0000}, 24, rx);
        chk_val(rx[23:16], 8'h3d, "error flag reported");
        chk_val(rx[15:0], exp_resp, "bad frames discarded");
        exp_resp = {7'h33, 9'h0a5};
        clear_err();
    endtask
    task automatic t_idle();
        w0 = wr_cnt;
        r0 = rc_cnt;
        HOST.stray_clocks();
        HOST.xfer(32'h0, 0, rx);
        chk_bit(SPI_ERR, 1'b0, "empty select");
        chk_val(wr_cnt + rc_cnt, w0 + r0, "no strobe when idle");
        chk_bit(SDO_OE, 1'b0, "sdo off when idle");
    endtask
    task automatic t_crc();
        @(negedge CLK) CRC_EN = 1'b1;
        w = {1'b1, 7'h41, 16'hc3a5};
        w0 = wr_cnt;
        HOST.xfer({w, 4'h0, crc4(w)}, 32, rx);
        chk_val(wr_cnt, w0 + 1, "crc write");
        chk_val(last_wd, 16'hc3a5, "crc write data");
        chk_val(rx[23:8], exp_resp, "crc response");
        chk_val(rx[3:0], crc4(rx[31:8]), "output crc");
        w = {1'b1, 7'h41, 16'h0f0f};
        HOST.xfer({w, 4'h0, crc4(w) ^ 4'h1}, 32, rx);
        chk_val(wr_cnt, w0 + 1, "bad crc dropped");
        chk_bit(SPI_ERR, 1'b1, "crc error");
        clear_err();
        HOST.xfer({8'h00, w}, 24, rx);
        chk_bit(SPI_ERR, 1'b1, "short crc frame");
        @(negedge CLK) CRC_EN = 1'b0;
        clear_err();
    endtask
    initial begin
        err_count = 0;
        num_checks = 0;
        wr_cnt = 0;
        rc_cnt = 0;
        SYS_RST = 1'b1;
        CRC_EN = 1'b0;
        SPI_ERR_CLR = 1'b0;
        FAULT_SUMMARY = 8'h5a;
        exp_resp = 16'h0000;
        repeat (5) @(negedge CLK);
        SYS_RST = 1'b0;
        repeat (3) @(negedge CLK);
        t_write();
        t_read();
        t_bad_len();
        t_idle();
        t_crc();
        close_out();
    end
    initial begin
        #100000;
        err_count++;
        close_out();
    end
endmodule
`default_nettype wire
